// ---- sdf_front.v ----
/*
 * Command front end of a closed-loop stepper drive: step/direction or
 * CW/CCW decode, enable sense, pulse rate filter, DIP switch resolution
 * decode, alarm and in-position open-collector outputs, fault LED.
 * Assumes all inputs synchronous to sys_clk; open-collector pins are
 * resolved outside from their enables.
 */
// Contract
// - LED flashes 1..5 times for overcurrent, vref, upload, overvoltage, following error.
// - Alarm output is off normally, conducts while overvoltage or overcurrent active.
// - In-position output conducts when actual position equals commanded position.
// - Sinking wiring: enable input high runs the drive, low disables it.
// - Sourcing or differential wiring inverts enable sense; low enables.
// - Step/direction mode: direction level selects rotation for following steps.
// - One step per active pulse edge; rising or falling chosen by setting.
// - All resolution switches on selects the stored software setting, also default.
// - Software resolution accepts only multiples of 50 from 200 to 50000.
// - Switch four on: codes 1..7 give 800 up to 51200 steps.
// - Switch four off: codes 0..7 give 1000 up to 40000 steps.
// - Switch five off selects step/direction, on selects CW/CCW pulses.
// - Switch six sets base direction, off CCW, on CW.
// - Switch seven off limits pulses to 200 kHz, on to 100 kHz.
// - Filter switch acts only while filter parameter is zero.
// - Switch eight turns pulse smoothing off or on.
`timescale 1ns/100ps
`default_nettype none
`include "sdf_regs.vh"

module sdf_front #(
    parameter MS_CYC    = `SDF_MS_CYC,
    parameter POS_W     = 32
) (
    input  wire             sys_clk,
    input  wire             rst,
    input  wire             step_pulse_in,
    input  wire             direction_in,
    input  wire             drive_enable_in,
    input  wire             input_wiring_sourcing,
    input  wire [3:0]       resolution_switches,
    input  wire             pulse_mode_switch,
    input  wire             direction_invert_switch,
    input  wire             pulse_filter_switch,
    input  wire             pulse_smoothing_switch,
    input  wire [7:0]       filter_param,
    input  wire             edge_falling_sel,
    input  wire [15:0]      sw_steps_rev,
    input  wire             sw_steps_wr,
    input  wire             fault_overcurrent,
    input  wire             fault_vref,
    input  wire             fault_param_upload,
    input  wire             fault_overvoltage,
    input  wire             fault_following,
    input  wire [POS_W-1:0] actual_position,
    output reg              fault_out_oe,
    output reg              in_position_out_oe,
    output reg              fault_led,
    output reg              drive_run,
    output reg              step_out,
    output reg              step_cw,
    output reg  [POS_W-1:0] target_position,
    output reg  [15:0]      steps_per_rev,
    output reg              sw_steps_reject,
    output reg              smoothing_on
);

    localparam [3:0] LED_IDLE  = 4'h1;
    localparam [3:0] LED_ON    = 4'h2;
    localparam [3:0] LED_OFF   = 4'h4;
    localparam [3:0] LED_PAUSE = 4'h8;

    localparam [15:0] FILT_FAST = `SDF_FILT_FAST_CYC;
    localparam [15:0] FILT_SLOW = `SDF_FILT_SLOW_CYC;
    localparam [15:0] FILT_UNIT = `SDF_FILT_UNIT_CYC;
    localparam [10:0] FLASH_MS  = `SDF_FLASH_MS;
    localparam [10:0] PAUSE_MS  = `SDF_PAUSE_MS;
    localparam [19:0] MS_LAST   = MS_CYC[19:0] - 20'h00001;

    ////////////////////////////////////////////////////////////////////
    // Enable sense and input edges

    reg         pulse_prev;
    reg         dir_prev;
    wire        next_run;
    wire        pulse_edge;
    wire        dir_edge;

    assign next_run = input_wiring_sourcing ? ~drive_enable_in
                                            : drive_enable_in;

    assign pulse_edge = edge_falling_sel ? (pulse_prev & ~step_pulse_in)
                                         : (~pulse_prev & step_pulse_in);
    assign dir_edge   = edge_falling_sel ? (dir_prev & ~direction_in)
                                         : (~dir_prev & direction_in);

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pulse_prev <= 1'b0;
            dir_prev   <= 1'b0;
            drive_run  <= 1'b0;
        end else begin
            pulse_prev <= step_pulse_in;
            dir_prev   <= direction_in;
            drive_run  <= next_run;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pulse rate filter

    reg  [15:0] gap_cnt;
    reg  [15:0] min_gap;
    wire [23:0] param_gap;
    wire        gap_ok;

    assign param_gap = filter_param * FILT_UNIT;
    assign gap_ok    = (gap_cnt >= min_gap);

    always @* begin
        if (filter_param != 8'h00) begin
            min_gap = param_gap[15:0];
        end else if (pulse_filter_switch) begin
            min_gap = FILT_SLOW;
        end else begin
            min_gap = FILT_FAST;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Step and direction decode

    reg  next_step;
    reg  next_cw;

    always @* begin
        next_step = 1'b0;
        next_cw   = step_cw;
        if (next_run && gap_ok) begin
            if (!pulse_mode_switch) begin
                next_step = pulse_edge;
                next_cw   = direction_in ~^ direction_invert_switch;
            end else if (pulse_edge) begin
                next_step = 1'b1;
                next_cw   = direction_invert_switch;
            end else if (dir_edge) begin
                next_step = 1'b1;
                next_cw   = ~direction_invert_switch;
            end
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gap_cnt         <= 16'hFFFF;
            step_out        <= 1'b0;
            step_cw         <= 1'b0;
            target_position <= {POS_W{1'b0}};
        end else begin
            step_out <= next_step;
            step_cw  <= next_cw;
            if (next_step) begin
                gap_cnt <= 16'h0001;
                if (next_cw) begin
                    target_position <= target_position + 1'b1;
                end else begin
                    target_position <= target_position - 1'b1;
                end
            end else if (gap_cnt != 16'hFFFF) begin
                gap_cnt <= gap_cnt + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Resolution

    reg  [15:0] sw_spr;
    reg  [15:0] next_spr;
    wire [2:0]  res_code;
    wire        sw_valid;

    // Switch on reads as 1; code is resolution_switches[2:0] inverted
    assign res_code = ~resolution_switches[2:0];
    assign sw_valid = (sw_steps_rev >= `SDF_SPR_MIN) &&
                      (sw_steps_rev <= `SDF_SPR_MAX) &&
                      ((sw_steps_rev % `SDF_SPR_STEP) == 16'h0000);

    always @* begin
        if (resolution_switches[3]) begin
            case (res_code)
                3'h0:    next_spr = sw_spr;
                3'h1:    next_spr = `SDF_SPR_A1;
                3'h2:    next_spr = `SDF_SPR_A2;
                3'h3:    next_spr = `SDF_SPR_A3;
                3'h4:    next_spr = `SDF_SPR_A4;
                3'h5:    next_spr = `SDF_SPR_A5;
                3'h6:    next_spr = `SDF_SPR_A6;
                default: next_spr = `SDF_SPR_A7;
            endcase
        end else begin
            case (res_code)
                3'h0:    next_spr = `SDF_SPR_B0;
                3'h1:    next_spr = `SDF_SPR_B1;
                3'h2:    next_spr = `SDF_SPR_B2;
                3'h3:    next_spr = `SDF_SPR_B3;
                3'h4:    next_spr = `SDF_SPR_B4;
                3'h5:    next_spr = `SDF_SPR_B5;
                3'h6:    next_spr = `SDF_SPR_B6;
                default: next_spr = `SDF_SPR_B7;
            endcase
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sw_spr          <= `SDF_SPR_RST;
            sw_steps_reject <= 1'b0;
            steps_per_rev   <= `SDF_SPR_RST;
            smoothing_on    <= 1'b0;
        end else begin
            sw_steps_reject <= sw_steps_wr & ~sw_valid;
            if (sw_steps_wr && sw_valid) begin
                sw_spr <= sw_steps_rev;
            end
            steps_per_rev <= next_spr;
            smoothing_on  <= pulse_smoothing_switch;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Alarm and in-position outputs

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fault_out_oe       <= 1'b0;
            in_position_out_oe <= 1'b0;
        end else begin
            fault_out_oe       <= fault_overcurrent | fault_overvoltage;
            in_position_out_oe <= (actual_position == target_position);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fault LED flasher

    reg  [19:0] ms_div;
    reg         ms_tick;
    reg  [3:0]  led_state;
    reg  [10:0] led_ms;
    reg  [2:0]  flash_left;
    reg  [2:0]  fault_code;

    // Lowest flash count wins when several faults stand together
    always @* begin
        if (fault_overcurrent) begin
            fault_code = `SDF_CODE_OVERCUR;
        end else if (fault_vref) begin
            fault_code = `SDF_CODE_VREF;
        end else if (fault_param_upload) begin
            fault_code = `SDF_CODE_PARAM;
        end else if (fault_overvoltage) begin
            fault_code = `SDF_CODE_OVERVOLT;
        end else if (fault_following) begin
            fault_code = `SDF_CODE_FOLLOW;
        end else begin
            fault_code = `SDF_CODE_NONE;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ms_div  <= 20'h00000;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (ms_div == MS_LAST);
            if (ms_div == MS_LAST) begin
                ms_div <= 20'h00000;
            end else begin
                ms_div <= ms_div + 20'h00001;
            end
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            led_state  <= LED_IDLE;
            led_ms     <= 11'h000;
            flash_left <= 3'h0;
            fault_led  <= 1'b0;
        end else begin
            case (led_state)
                LED_IDLE: begin
                    fault_led <= 1'b0;
                    if (fault_code != `SDF_CODE_NONE && ms_tick) begin
                        flash_left <= fault_code;
                        led_ms     <= FLASH_MS;
                        fault_led  <= 1'b1;
                        led_state  <= LED_ON;
                    end
                end
                LED_ON: begin
                    if (ms_tick) begin
                        led_ms <= led_ms - 11'h001;
                        if (led_ms == 11'h001) begin
                            fault_led  <= 1'b0;
                            flash_left <= flash_left - 3'h1;
                            if (flash_left == 3'h1) begin
                                led_ms    <= PAUSE_MS;
                                led_state <= LED_PAUSE;
                            end else begin
                                led_ms    <= FLASH_MS;
                                led_state <= LED_OFF;
                            end
                        end
                    end
                end
                LED_OFF: begin
                    if (ms_tick) begin
                        led_ms <= led_ms - 11'h001;
                        if (led_ms == 11'h001) begin
                            led_ms    <= FLASH_MS;
                            fault_led <= 1'b1;
                            led_state <= LED_ON;
                        end
                    end
                end
                LED_PAUSE: begin
                    if (ms_tick) begin
                        led_ms <= led_ms - 11'h001;
                        if (led_ms == 11'h001) begin
                            led_state <= LED_IDLE;
                        end
                    end
                end
                default: begin
                    fault_led <= 1'b0;
                    led_state <= LED_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- sdf_regs.vh ----
/*
 * Constants of the step/direction front end: timing counts, switch
 * decode tables, software resolution limits and fault codes.
 * Assumes a 50 MHz system clock; included by the design, checker and test files.
 */
`ifndef SDF_REGS_VH
`define SDF_REGS_VH

// Minimum step spacing in 50 MHz cycles: 200 kHz and 100 kHz limits
`define SDF_FILT_FAST_CYC   16'h00FA
`define SDF_FILT_SLOW_CYC   16'h01F4
// One filter parameter step of 1 us, in cycles
`define SDF_FILT_UNIT_CYC   16'h0032

// LED timing: cycles per millisecond tick, flash and pause lengths in ms
`define SDF_MS_CYC          20'h0C350
`define SDF_FLASH_MS        11'h0C8
`define SDF_PAUSE_MS        11'h4B0

// Software steps per revolution
`define SDF_SPR_MIN         16'h00C8
`define SDF_SPR_MAX         16'hC350
`define SDF_SPR_STEP        16'h0032
`define SDF_SPR_RST         16'h2710

// Steps per revolution, switch four on, codes 1..7
`define SDF_SPR_A1          16'h0320
`define SDF_SPR_A2          16'h0640
`define SDF_SPR_A3          16'h0C80
`define SDF_SPR_A4          16'h1900
`define SDF_SPR_A5          16'h3200
`define SDF_SPR_A6          16'h6400
`define SDF_SPR_A7          16'hC800

// Steps per revolution, switch four off, codes 0..7
`define SDF_SPR_B0          16'h03E8
`define SDF_SPR_B1          16'h07D0
`define SDF_SPR_B2          16'h0FA0
`define SDF_SPR_B3          16'h1388
`define SDF_SPR_B4          16'h1F40
`define SDF_SPR_B5          16'h2710
`define SDF_SPR_B6          16'h4E20
`define SDF_SPR_B7          16'h9C40

// Fault flash counts
`define SDF_CODE_NONE       3'h0
`define SDF_CODE_OVERCUR    3'h1
`define SDF_CODE_VREF       3'h2
`define SDF_CODE_PARAM      3'h3
`define SDF_CODE_OVERVOLT   3'h4
`define SDF_CODE_FOLLOW     3'h5

`endif

// ---- sdf_front_properties.sv ----
/* Checker for the sdf_front ports: alarm, in-position, enable, steps, resolution.
   Assumes sdf_regs.vh and one sys_clk domain reset by rst. */
`timescale 1ns/100ps
`default_nettype none
`include "sdf_regs.vh"
module sdf_front_props #(
    parameter MS_CYC = 50000,
    parameter POS_W  = 32
) (
    input wire logic             sys_clk,
    input wire logic             rst,
    input wire logic             direction_in,
    input wire logic             drive_enable_in,
    input wire logic             input_wiring_sourcing,
    input wire logic [3:0]       resolution_switches,
    input wire logic             pulse_mode_switch,
    input wire logic             direction_invert_switch,
    input wire logic [15:0]      sw_steps_rev,
    input wire logic             sw_steps_wr,
    input wire logic             fault_overcurrent,
    input wire logic             fault_overvoltage,
    input wire logic [POS_W-1:0] actual_position,
    input wire logic             fault_out_oe,
    input wire logic             in_position_out_oe,
    input wire logic             drive_run,
    input wire logic             step_out,
    input wire logic             step_cw,
    input wire logic [POS_W-1:0] target_position,
    input wire logic [15:0]      steps_per_rev,
    input wire logic             sw_steps_reject
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    localparam logic [127:0] OFF_TAB = {`SDF_SPR_B7, `SDF_SPR_B6, `SDF_SPR_B5, `SDF_SPR_B4,
                                        `SDF_SPR_B3, `SDF_SPR_B2, `SDF_SPR_B1, `SDF_SPR_B0};
    function automatic logic [15:0] spr_of(input logic [3:0] s);
        logic [2:0] c;
        c = ~s[2:0];
        return s[3] ? (`SDF_SPR_A1 << (c - 3'h1)) : OFF_TAB[c*16 +: 16];
    endfunction
    function automatic logic bad_spr(input logic [15:0] v);
        return v < `SDF_SPR_MIN || v > `SDF_SPR_MAX || v % `SDF_SPR_STEP != 16'h0000;
    endfunction
    sequence s_good_write;
        sw_steps_wr && !bad_spr(sw_steps_rev) && resolution_switches == 4'hF;
    endsequence
    sequence s_quiet;
        !sw_steps_wr && resolution_switches == 4'hF;
    endsequence
    a_alarm_follow: assert property (!$past(rst) |->
        fault_out_oe == $past(fault_overcurrent || fault_overvoltage)) else $error("alarm wrong");
    a_inpos_match: assert property (!$past(rst) |->
        in_position_out_oe == $past(actual_position == target_position)) else $error("inpos");
    a_enable_sense: assert property (!$past(rst) |->
        drive_run == $past(drive_enable_in ^ input_wiring_sourcing)) else $error("enable wrong");
    a_step_spacing: assert property (step_out |=> !step_out [*8])
        else $error("steps too close");
    a_target_track: assert property (!$past(rst) |-> target_position ==
        $past(target_position) + (step_out ? (step_cw ? 1 : -1) : 0)) else $error("target");
    a_sd_direction: assert property (step_out && !$past(pulse_mode_switch) |->
        step_cw == $past(direction_in ~^ direction_invert_switch)) else $error("step direction");
    a_switch_map: assert property (!$past(rst) && $past(resolution_switches) != 4'hF |->
        steps_per_rev == spr_of($past(resolution_switches))) else $error("switch resolution");
    a_write_reject: assert property (!$past(rst) |->
        sw_steps_reject == $past(sw_steps_wr && bad_spr(sw_steps_rev))) else $error("reject");
    a_soft_resolution: assert property (s_good_write ##1 s_quiet |=>
        steps_per_rev == $past(sw_steps_rev, 2)) else $error("software resolution");
endmodule
bind sdf_front sdf_front_props #(.MS_CYC(MS_CYC), .POS_W(POS_W)) sdf_front_props_inst (
    .sys_clk(sys_clk), .rst(rst), .direction_in(direction_in),
    .drive_enable_in(drive_enable_in), .input_wiring_sourcing(input_wiring_sourcing),
    .resolution_switches(resolution_switches), .pulse_mode_switch(pulse_mode_switch),
    .direction_invert_switch(direction_invert_switch), .sw_steps_rev(sw_steps_rev),
    .sw_steps_wr(sw_steps_wr), .fault_overcurrent(fault_overcurrent),
    .fault_overvoltage(fault_overvoltage), .actual_position(actual_position),
    .fault_out_oe(fault_out_oe), .in_position_out_oe(in_position_out_oe),
    .drive_run(drive_run), .step_out(step_out), .step_cw(step_cw),
    .target_position(target_position), .steps_per_rev(steps_per_rev),
    .sw_steps_reject(sw_steps_reject)
);
`default_nettype wire

// ---- sdf_ctrl_model.sv ----
/* Motion controller model driving the step and direction lines.
   Assumes the bench calls its tasks; lines change on falling clock edges. */
`timescale 1ns/100ps
`default_nettype none
module sdf_ctrl_model (
    input  wire logic sys_clk,
    output var  logic step_pulse_in,
    output var  logic direction_in
);
    initial begin
        step_pulse_in = 1'b0;
        direction_in  = 1'b0;
    end
    // Direction settles 251 cycles before the next step edge
    task automatic set_dir(input logic lvl);
        @(negedge sys_clk);
        direction_in = lvl;
        repeat (250) @(negedge sys_clk);
    endtask
    // One pulse on either line, high time and period in cycles
    task automatic pulse(input logic on_dir, input int hi, input int per);
        @(negedge sys_clk);
        if (on_dir) direction_in = 1'b1;
        else step_pulse_in = 1'b1;
        repeat (hi) @(negedge sys_clk);
        if (on_dir) direction_in = 1'b0;
        else step_pulse_in = 1'b0;
        repeat (per - hi - 1) @(negedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ---- step_dir_input_and_fault_indication_test.sv ----
/* Self-checking bench for sdf_front with a motion controller model.
   Assumes 50 MHz sys_clk; the millisecond tick is shortened to 2 cycles. */
`timescale 1ns/100ps
`default_nettype none
`include "sdf_regs.vh"
module step_dir_input_and_fault_indication_test;
    logic        sys_clk, rst, step_pulse_in, direction_in, en, wiring, mode, inv;
    logic        filt, smooth, fall, wr, alarm, inpos, led, run, stp, cw, rej, smo;
    logic [3:0]  sw;
    logic [7:0]  fparam, lfsr;
    logic [15:0] spr_in, spr;
    logic [4:0]  faults;
    logic [31:0] apos, tgt;
    logic        exp_q [$];
    logic [15:0] wv [6] = '{16'h0190, 16'h00C8, 16'hC350, 16'h0096, 16'hC382, 16'h00C9};
    int          fails, checked, exp_pos, n, t;
    localparam logic [127:0] OFF_TAB = {`SDF_SPR_B7, `SDF_SPR_B6, `SDF_SPR_B5, `SDF_SPR_B4,
                                        `SDF_SPR_B3, `SDF_SPR_B2, `SDF_SPR_B1, `SDF_SPR_B0};
    sdf_front #(.MS_CYC(2), .POS_W(32)) sdf_front_inst (
        .sys_clk(sys_clk), .rst(rst), .step_pulse_in(step_pulse_in),
        .direction_in(direction_in), .drive_enable_in(en), .input_wiring_sourcing(wiring),
        .resolution_switches(sw), .pulse_mode_switch(mode), .direction_invert_switch(inv),
        .pulse_filter_switch(filt), .pulse_smoothing_switch(smooth), .filter_param(fparam),
        .edge_falling_sel(fall), .sw_steps_rev(spr_in), .sw_steps_wr(wr),
        .fault_overcurrent(faults[0]), .fault_vref(faults[1]), .fault_param_upload(faults[2]),
        .fault_overvoltage(faults[3]), .fault_following(faults[4]), .actual_position(apos),
        .fault_out_oe(alarm), .in_position_out_oe(inpos), .fault_led(led), .drive_run(run),
        .step_out(stp), .step_cw(cw), .target_position(tgt), .steps_per_rev(spr),
        .sw_steps_reject(rej), .smoothing_on(smo)
    );
    sdf_ctrl_model sdf_ctrl_model_inst (
        .sys_clk(sys_clk), .step_pulse_in(step_pulse_in), .direction_in(direction_in)
    );
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] spr_of(input logic [3:0] s);
        logic [2:0] c;
        c = ~s[2:0];
        return s[3] ? (16'h0320 << (c - 3'h1)) : OFF_TAB[c*16 +: 16];
    endfunction
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("BAD at %0t seen %0h expected %0h", $time, seen, want);
        end
    endtask
    task automatic give_verdict;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic step(input logic on_dir, input int per, input logic take, input logic want);
        if (take) begin
            exp_q.push_back(want);
            exp_pos += want ? 1 : -1;
        end
        sdf_ctrl_model_inst.pulse(on_dir, 130, per);
    endtask
    // Counts flashes of one group; returns once the LED has been dark 1200 cycles
    task automatic led_group(output int cnt);
        int   d;
        logic p;
        cnt = 0;
        d = 0;
        p = 1'b0;
        while (d < 1200) begin
            @(negedge sys_clk);
            if (led === 1'b1 && !p) cnt++;
            d = (led === 1'b1 || cnt == 0) ? 0 : d + 1;
            p = led;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge sys_clk) begin
        if (stp === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else check(cw, exp_q.pop_front());
        end
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        give_verdict();
    end
    initial begin
        {rst, en, wiring, mode, inv, filt, smooth, fall, wr} = 9'h180;
        sw = 4'hF;
        fparam = 8'h00;
        spr_in = 16'h0000;
        faults = 5'h00;
        apos = 32'h0;
        lfsr = 8'h60;
        {fails, checked, exp_pos} = '0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        check(spr, `SDF_SPR_RST);
        rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            {wiring, en} = i[1:0];
            repeat (2) @(negedge sys_clk);
            check(run, en ^ wiring);
        end
        step(1'b0, 260, 1'b0, 1'b0);
        en = 1'b0;
        for (int i = 0; i < 8; i++) begin
            {fall, inv} = i[2:1];
            sdf_ctrl_model_inst.set_dir(i[0]);
            step(1'b0, 260, 1'b1, i[0] ~^ i[1]);
        end
        sdf_ctrl_model_inst.set_dir(1'b0);
        mode = 1'b1;
        for (int i = 0; i < 4; i++) begin
            inv = i[1];
            step(i[0], 260, 1'b1, i[0] ^ i[1]);
        end
        {mode, inv, filt} = 3'b011;
        for (int j = 0; j < 2; j++) begin
            fparam = j ? 8'h02 : 8'h00;
            repeat (600) @(negedge sys_clk);
            for (int i = 0; i < 3; i++) step(1'b0, 300, j == 1 || i != 1, 1'b0);
        end
        repeat (4) @(negedge sys_clk);
        check(tgt, exp_pos);
        check(exp_q.size(), 0);
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            apos = i[0] ? tgt : {24'h0, lfsr};
            repeat (2) @(negedge sys_clk);
            check(inpos, apos == tgt);
        end
        for (int i = 0; i < 15; i++) begin
            sw = i[3:0];
            repeat (2) @(negedge sys_clk);
            check(spr, spr_of(sw));
        end
        sw = 4'hF;
        for (int i = 0; i < 6; i++) begin
            spr_in = wv[i];
            wr = 1'b1;
            @(negedge sys_clk) wr = 1'b0;
            check(rej, i > 2);
            @(negedge sys_clk);
            check(spr, i > 2 ? 16'hC350 : wv[i]);
        end
        smooth = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(smo, 1'b1);
        for (int k = 1; k <= 5; k++) begin
            faults = 5'h01 << (k - 1);
            repeat (2) @(negedge sys_clk);
            check(alarm, k == 1 || k == 4);
            led_group(n);
            check(n, k);
            t = 0;
            while (led !== 1'b1 && t < 2000) begin
                @(negedge sys_clk);
                t++;
            end
            check(t > 900 && t < 2000, 1'b1);
            faults = 5'h00;
            led_group(n);
            check(n, k);
            check(alarm, 1'b0);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
